// ---- rtl/free_running_timer.sv ----
// Free-running 16-bit timer with compare toggle output, match request and capture.
// Assumes a CPU special-function register port with bit, byte and word accesses
// and a capture input already synchronous to the system clock.

module free_running_timer (
	input  wire logic              clk_sys_in,      // System clock.
	input  wire logic              rstn_in,         // Synchronous reset, active low.
	input  wire logic [15:0]       sfr_addr_in,     // Register address.
	input  wire logic              sfr_wr_in,       // Write strobe, one cycle.
	input  wire logic              sfr_rd_in,       // Read strobe, one cycle.
	input  wire frt_pkg::acc_size_t sfr_size_in,    // Bit, byte or word access.
	input  wire logic [2:0]        sfr_bit_in,      // Bit number for bit access.
	input  wire logic              sfr_short_dir_in, // Short direct addressing.
	input  wire logic [15:0]       sfr_wdata_in,    // Write data, low aligned.
	input  wire logic              ext_irq_input_in, // Capture input.
	output logic [15:0]            sfr_rdata_out,   // Read data, next cycle.
	output logic                   match_irq_out,   // Match request pulse.
	output logic                   toggle_out_pin_out // Timer toggle output.
);
	import frt_pkg::*;

	// ==========================================================================
	// State
	// ==========================================================================
	logic [15:0] match_value_q;
	logic [15:0] free_run_count_q;
	logic [15:0] capture_value_q;
	logic [7:0]  timer_mode_ctrl_q;
	logic        toggle_q;
	logic        irq_q;
	logic        cap_in_q;
	logic [15:0] rdata_q;

	count_tick_if tick_if ();

	count_clock_divider u_divider (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.tick_if    (tick_if)
	);

	// ==========================================================================
	// Access decode
	// ==========================================================================
	wire is_word  = (sfr_size_in == ACC_WORD);
	wire is_byte  = (sfr_size_in == ACC_BYTE);
	wire is_bit   = (sfr_size_in == ACC_BIT);
	wire word_ok  = is_word && sfr_short_dir_in;

	function automatic logic hits(input logic [15:0] addr, input logic [15:0] base);
		hits = (addr == base);
	endfunction : hits

	wire cmp_lo   = hits(sfr_addr_in, MATCH_VALUE_ADDR);
	wire cmp_hi   = hits(sfr_addr_in, MATCH_VALUE_ADDR + 16'h0001);
	wire cnt_lo   = hits(sfr_addr_in, FREE_RUN_COUNT_ADDR);
	wire cnt_hi   = hits(sfr_addr_in, FREE_RUN_COUNT_ADDR + 16'h0001);
	wire cap_lo   = hits(sfr_addr_in, CAPTURE_VALUE_ADDR);
	wire cap_hi   = hits(sfr_addr_in, CAPTURE_VALUE_ADDR + 16'h0001);
	wire mode_hit = hits(sfr_addr_in, TIMER_MODE_CTRL_ADDR);

	wire cmp_wr_lo = sfr_wr_in && ((word_ok && cmp_lo) || (is_byte && cmp_lo));
	wire cmp_wr_hi = sfr_wr_in && (is_byte && cmp_hi);
	wire cmp_wr_w  = sfr_wr_in && word_ok && cmp_lo;

	// mode writes by bit or byte
	wire mode_wr_byte = sfr_wr_in && mode_hit && is_byte;
	wire mode_wr_bit  = sfr_wr_in && mode_hit && is_bit;

	// ==========================================================================
	// Counter, match and toggle
	// ==========================================================================
	wire        tick      = tick_if.tick;
	wire [15:0] count_nxt = free_run_count_q + 16'h0001;
	wire        match_hit = tick && (count_nxt == match_value_q);
	wire        toggle_en = timer_mode_ctrl_q[TOGGLE_EN_BIT];

	assign tick_if.clock_sel = {timer_mode_ctrl_q[COUNT_CLOCK_SEL_HI_BIT],
	                            timer_mode_ctrl_q[COUNT_CLOCK_SEL_LO_BIT]};

	// ==========================================================================
	// Capture edge detect
	// ==========================================================================
	wire [1:0] cap_sel  = {timer_mode_ctrl_q[CAPTURE_EDGE_SEL_HI_BIT],
	                       timer_mode_ctrl_q[CAPTURE_EDGE_SEL_LO_BIT]};
	wire       rise     = ext_irq_input_in && !cap_in_q;
	wire       fall     = !ext_irq_input_in && cap_in_q;
	wire       cap_take = (cap_sel == 2'h1 && rise) || (cap_sel == 2'h2 && fall) ||
	                      (cap_sel == 2'h3 && (rise || fall));

	// ==========================================================================
	// Read multiplexer
	// ==========================================================================
	function automatic logic [15:0] word_read(input logic [15:0] addr,
	                                          input logic [15:0] cnt,
	                                          input logic [15:0] cap);
		if (addr == FREE_RUN_COUNT_ADDR)
			word_read = cnt;
		else if (addr == CAPTURE_VALUE_ADDR)
			word_read = cap;
		else
			word_read = 16'h0000;
	endfunction : word_read

	// The compare register is write-only, so every read of it returns zero.
	wire [15:0] rd_word = word_read(sfr_addr_in, free_run_count_q, capture_value_q);
	wire [7:0]  rd_byte = cnt_lo ? free_run_count_q[7:0] :
	                      cnt_hi ? free_run_count_q[15:8] :
	                      cap_lo ? capture_value_q[7:0] :
	                      cap_hi ? capture_value_q[15:8] :
	                      mode_hit ? timer_mode_ctrl_q : 8'h00;
	wire [15:0] rdata_d = !sfr_rd_in ? 16'h0000 :
	                      word_ok ? rd_word :
	                      is_byte ? {8'h00, rd_byte} :
	                      (is_bit && mode_hit) ? {15'h0000, timer_mode_ctrl_q[sfr_bit_in]} :
	                      16'h0000;

	// ==========================================================================
	// Registers
	// ==========================================================================
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			match_value_q <= MATCH_VALUE_RST;
		end else if (cmp_wr_w) begin
			match_value_q <= sfr_wdata_in;
		end else if (cmp_wr_lo) begin
			match_value_q[7:0] <= sfr_wdata_in[7:0];
		end else if (cmp_wr_hi) begin
			match_value_q[15:8] <= sfr_wdata_in[7:0];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			free_run_count_q <= FREE_RUN_COUNT_RST;
		end else if (tick) begin
			free_run_count_q <= count_nxt;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			timer_mode_ctrl_q <= TIMER_MODE_CTRL_RST;
		end else if (mode_wr_byte) begin
			timer_mode_ctrl_q <= sfr_wdata_in[7:0];
		end else if (mode_wr_bit) begin
			timer_mode_ctrl_q[sfr_bit_in] <= sfr_wdata_in[0];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (cap_take) begin
			capture_value_q <= free_run_count_q;
		end
	end

	// output gated until software enables it
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			toggle_q <= 1'b0;
			irq_q    <= 1'b0;
			cap_in_q <= 1'b0;
			rdata_q  <= 16'h0000;
		end else begin
			if (match_hit && toggle_en)
				toggle_q <= !toggle_q;
			irq_q    <= match_hit;
			cap_in_q <= ext_irq_input_in;
			rdata_q  <= rdata_d;
		end
	end

	assign sfr_rdata_out      = rdata_q;
	assign match_irq_out      = irq_q;
	assign toggle_out_pin_out = toggle_q;

	// ==========================================================================
	// Assertions
	// ==========================================================================
	property p_toggle_on_match;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(match_hit && toggle_en) |=> (toggle_out_pin_out != $past(toggle_out_pin_out));
	endproperty
	a_toggle_on_match: assert property (p_toggle_on_match) else $error("Toggle missed on match.");

	property p_no_clear;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		match_hit |=> (free_run_count_q == $past(match_value_q)) ##1 (free_run_count_q != 16'h0000 ||
		              $past(free_run_count_q) == 16'hffff || $past(free_run_count_q) == 16'h0000);
	endproperty
	a_no_clear: assert property (p_no_clear) else $error("Counter cleared by match.");

	property p_irq_on_match;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		match_hit |=> match_irq_out && (free_run_count_q == match_value_q || $past(cmp_wr_lo || cmp_wr_hi));
	endproperty
	a_irq_on_match: assert property (p_irq_on_match) else $error("Match request missing.");

	property p_no_toggle_without_tick;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		!tick |=> $stable(toggle_out_pin_out) && $stable(free_run_count_q);
	endproperty
	a_no_toggle_without_tick: assert property (p_no_toggle_without_tick) else $error("Change without tick.");

	property p_no_capture;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(cap_sel == 2'h0) |=> $stable(capture_value_q);
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("Capture with edges disabled.");

	property p_cmp_write_only;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(sfr_rd_in && (cmp_lo || cmp_hi)) |=> (sfr_rdata_out == 16'h0000);
	endproperty
	a_cmp_write_only: assert property (p_cmp_write_only) else $error("Compare register readable.");

	property p_count_not_writable;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(sfr_wr_in && (cnt_lo || cnt_hi) && !tick) |=> $stable(free_run_count_q);
	endproperty
	a_count_not_writable: assert property (p_count_not_writable) else $error("Counter took a write.");

	property p_mode_byte_write;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		mode_wr_byte |=> (timer_mode_ctrl_q == $past(sfr_wdata_in[7:0]));
	endproperty
	a_mode_byte_write: assert property (p_mode_byte_write) else $error("Mode byte write lost.");

	property p_word_needs_short;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(sfr_wr_in && is_word && !sfr_short_dir_in) |=> $stable(match_value_q) && $stable(timer_mode_ctrl_q);
	endproperty
	a_word_needs_short: assert property (p_word_needs_short) else $error("Word access without short direct.");

	property p_wrap;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(tick && free_run_count_q == 16'hffff) |=> (free_run_count_q == 16'h0000);
	endproperty
	a_wrap: assert property (p_wrap) else $error("Counter did not wrap.");

	property p_irq_single;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		match_irq_out |=> !match_irq_out [*3];
	endproperty
	a_irq_single: assert property (p_irq_single) else $error("Match request repeated.");

	property p_toggle_only_on_match;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		!(match_hit && toggle_en) |=> $stable(toggle_out_pin_out);
	endproperty
	a_toggle_only_on_match: assert property (p_toggle_only_on_match) else $error("Toggle without match.");

	property p_irq_needs_match;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		!match_hit |=> !match_irq_out;
	endproperty
	a_irq_needs_match: assert property (p_irq_needs_match) else $error("Request without match.");

	property p_tick_increment;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		tick |=> (free_run_count_q == $past(free_run_count_q) + 16'h0001);
	endproperty
	a_tick_increment: assert property (p_tick_increment) else $error("Counter did not step.");

	// The divider keys on its two low bits, so ticks never come closer than four clocks.
	property p_tick_spacing;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		tick |=> !tick [*3];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("Count ticks too close.");

	property p_count_read;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(sfr_rd_in && word_ok && cnt_lo) |=> (sfr_rdata_out == $past(free_run_count_q));
	endproperty
	a_count_read: assert property (p_count_read) else $error("Counter read wrong.");

	property p_capture_take;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		cap_take |=> (capture_value_q == $past(free_run_count_q));
	endproperty
	a_capture_take: assert property (p_capture_take) else $error("Capture missed the count.");

	property p_mode_bit_write;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		mode_wr_bit |=> (timer_mode_ctrl_q[$past(sfr_bit_in)] == $past(sfr_wdata_in[0]));
	endproperty
	a_mode_bit_write: assert property (p_mode_bit_write) else $error("Mode bit write lost.");

endmodule : free_running_timer

// ---- rtl/frt_pkg.sv ----
// Constants shared by the free-running timer and its count clock divider.
// Assumes one system clock and a CPU-side special-function register port.
package frt_pkg;

	// ==========================================================================
	// Register addresses and reset values
	// ==========================================================================
	localparam logic [15:0] MATCH_VALUE_ADDR      = 16'hff16;
	localparam logic [15:0] FREE_RUN_COUNT_ADDR   = 16'hff18;
	localparam logic [15:0] CAPTURE_VALUE_ADDR    = 16'hff1a;
	localparam logic [15:0] TIMER_MODE_CTRL_ADDR  = 16'hff48;
	localparam logic [15:0] MATCH_VALUE_RST       = 16'hffff;
	localparam logic [15:0] FREE_RUN_COUNT_RST    = 16'h0000;
	localparam logic [7:0]  TIMER_MODE_CTRL_RST   = 8'h00;

	// ==========================================================================
	// Mode control field positions
	// ==========================================================================
	localparam int TOGGLE_EN_BIT           = 0;
	localparam int COUNT_CLOCK_SEL_LO_BIT  = 2;
	localparam int COUNT_CLOCK_SEL_HI_BIT  = 3;
	localparam int CAPTURE_EDGE_SEL_LO_BIT = 4;
	localparam int CAPTURE_EDGE_SEL_HI_BIT = 5;

	// ==========================================================================
	// Access sizes and count clock prescaler
	// ==========================================================================
	typedef enum logic [1:0] {
		ACC_BIT  = 2'h0,
		ACC_BYTE = 2'h1,
		ACC_WORD = 2'h3
	} acc_size_t;

	localparam int          PRESCALE_W    = 8;
	localparam logic [7:0]  PRESCALE_MASK0 = 8'h03;
	localparam logic [7:0]  PRESCALE_MASK1 = 8'h0f;
	localparam logic [7:0]  PRESCALE_MASK2 = 8'h3f;
	localparam logic [7:0]  PRESCALE_MASK3 = 8'hff;
	localparam logic [7:0]  PRESCALE_RST   = 8'h00;

endpackage : frt_pkg

// ---- rtl/count_tick_if.sv ----
// Carries the count clock selection to the divider and the count tick back.
// Assumes both ends run on the same system clock.
interface count_tick_if;
	logic [1:0] clock_sel;
	logic       tick;

	modport divider (input clock_sel, output tick);
	modport timer   (output clock_sel, input tick);
endinterface : count_tick_if

// ---- rtl/count_clock_divider.sv ----
// Count clock divider: one tick pulse per selected number of system clocks.
// Assumes the selection comes straight from the mode control register.
module count_clock_divider
	import frt_pkg::*;
(
	input  wire logic      clk_sys_in, // System clock.
	input  wire logic      rstn_in,    // Synchronous reset, active low.
	count_tick_if.divider  tick_if     // Selection in, tick out.
);

	logic [PRESCALE_W-1:0] div_q;
	logic                  tick_q;
	logic [PRESCALE_W-1:0] sel_mask;

	function automatic logic [PRESCALE_W-1:0] mask_of(input logic [1:0] sel);
		unique case (sel)
			2'h0: mask_of = PRESCALE_MASK0;
			2'h1: mask_of = PRESCALE_MASK1;
			2'h2: mask_of = PRESCALE_MASK2;
			2'h3: mask_of = PRESCALE_MASK3;
		endcase
	endfunction : mask_of

	assign sel_mask     = mask_of(tick_if.clock_sel);
	assign tick_if.tick = tick_q;

	// A change of selection may shorten one interval; the divider is never reset
	// on selection change so the tick spacing stays at least four clocks.
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			div_q  <= PRESCALE_RST;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_q + 8'h01;
			tick_q <= ((div_q & sel_mask) == sel_mask);
		end
	end

endmodule : count_clock_divider

// ---- test/toggle_load.sv ----
// Model of the circuit on the timer toggle pin: it counts level changes.
// Assumes the pin is sampled on the system clock and starts low.
module toggle_load (
	input  wire logic clk_sys_in, // System clock.
	input  wire logic pin_in,     // Toggle pin level.
	output int        edges_out   // Level changes seen.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_q  = 1'b0;
	int   count_q = 0;
	assign edges_out = count_q;
	// latch starts low
	// A change between known levels counts, as does an unknown level after an unknown one; the single unknown sample before reset is no edge.
	always @(posedge clk_sys_in) begin
		if (pin_in === ~last_q)
			count_q <= count_q + 1;
		last_q <= pin_in;
	end
endmodule : toggle_load

// ---- test/free_running_timer_toggle_output_bench.sv ----
// Self-checking bench for the free-running timer with toggle output.
// Assumes the register port contract of the timer and the pin load model.
module free_running_timer_toggle_output_bench
	import frt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 0, rstn_in = 0, wr = 0, rd = 0, short_dir = 0, ext_in = 0, t_exp = 0;
	logic [15:0] addr = 0, wdata = 0, got, c0, c1, cmp;
	logic [2:0] bitn = 0;
	acc_size_t size = ACC_BYTE;
	logic [15:0] rdata;
	logic irq, tog;
	int edges, mismatches = 0, n_checks = 0, seed = 84, i, k, j;
	always #5 clk_sys_in = ~clk_sys_in;
	free_running_timer dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .sfr_addr_in(addr),
		.sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_size_in(size), .sfr_bit_in(bitn),
		.sfr_short_dir_in(short_dir), .sfr_wdata_in(wdata), .ext_irq_input_in(ext_in),
		.sfr_rdata_out(rdata), .match_irq_out(irq), .toggle_out_pin_out(tog));
	toggle_load load (.clk_sys_in(clk_sys_in), .pin_in(tog), .edges_out(edges));
	// ==========================================================================
	// Checks and report
	// ==========================================================================
	task automatic check_eq(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask : check_eq
	// Counter values drift with the tick, so a window is accepted.
	task automatic check_near(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] span);
		logic [15:0] d;
		d = g - lo;
		n_checks++;
		if ($isunknown(g) || d > span) begin
			mismatches++;
			$display("BAD %0t got %h expected %h plus up to %h", $time, g, lo, span);
		end
	endtask : check_near
	// Ticks expected in a span of system clocks; the divisor is four times four per select step.
	function automatic logic [15:0] exp_ticks(input int sel, input int span);
		exp_ticks = 16'(span / (4 << (2 * sel)));
	endfunction : exp_ticks
	function automatic logic [15:0] exp_low_bits(input int n);
		exp_low_bits = 16'((1 << n) - 1);
	endfunction : exp_low_bits
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	// ==========================================================================
	// Register port cycle
	// ==========================================================================
	task automatic bus(input logic w, input logic [15:0] a, input acc_size_t s, input logic sh,
		input logic [15:0] d, input logic [2:0] b);
		@(posedge clk_sys_in);
		#1;
		wr = w;
		rd = !w;
		addr = a;
		size = s;
		short_dir = sh;
		wdata = d;
		bitn = b;
		@(posedge clk_sys_in);
		#1;
		wr = 0;
		rd = 0;
		got = rdata;
	endtask : bus
	task automatic rd_count();
		bus(0, FREE_RUN_COUNT_ADDR, ACC_WORD, 1, 16'h0000, 3'h0);
	endtask : rd_count
	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		repeat (20) @(posedge clk_sys_in);
		#1;
		rstn_in = 1;
		bus(0, TIMER_MODE_CTRL_ADDR, ACC_BYTE, 0, 16'h0000, 3'h0);
		check_eq(got, 16'(TIMER_MODE_CTRL_RST));
		bus(0, MATCH_VALUE_ADDR, ACC_WORD, 1, 16'h0000, 3'h0);
		check_eq(got, 16'h0000);
		bus(0, 16'hff30, ACC_BYTE, 0, 16'h0000, 3'h0);
		check_eq(got, 16'h0000);
		rd_count();
		check_near(got, FREE_RUN_COUNT_RST, 16'h0004);
		c0 = got;
		bus(1, FREE_RUN_COUNT_ADDR, ACC_WORD, 1, 16'($random(seed)), 3'h0);
		rd_count();
		check_near(got, c0, 16'h0002);
		bus(0, FREE_RUN_COUNT_ADDR, ACC_WORD, 0, 16'h0000, 3'h0);
		check_eq(got, 16'h0000);
		bus(0, FREE_RUN_COUNT_ADDR + 16'h0001, ACC_BYTE, 0, 16'h0000, 3'h0);
		check_eq(got, 16'h0000);
		bus(0, FREE_RUN_COUNT_ADDR, ACC_BYTE, 0, 16'h0000, 3'h0);
		check_near(got, c0, 16'h0004);
		for (i = 0; i < 4; i++) begin
			c0 = 16'($random(seed) & 8'hff);
			bus(1, TIMER_MODE_CTRL_ADDR, ACC_BYTE, 0, c0, 3'h0);
			bus(0, TIMER_MODE_CTRL_ADDR, ACC_BYTE, 0, 16'h0000, 3'h0);
			check_eq(got, c0);
		end
		bus(1, TIMER_MODE_CTRL_ADDR, ACC_BYTE, 0, 16'h0000, 3'h0);
		for (i = 0; i < 8; i++) begin
			bus(1, TIMER_MODE_CTRL_ADDR, ACC_BIT, 0, 16'h0001, 3'(i));
			bus(0, TIMER_MODE_CTRL_ADDR, ACC_BIT, 0, 16'h0000, 3'(i));
			check_eq(got, 16'h0001);
			bus(0, TIMER_MODE_CTRL_ADDR, ACC_BYTE, 0, 16'h0000, 3'h0);
			check_eq(got, exp_low_bits(i + 1));
		end
		// Each clock select code sets the tick rate over a 1024-cycle span.
		for (i = 0; i < 4; i++) begin
			bus(1, TIMER_MODE_CTRL_ADDR, ACC_BYTE, 0, 16'(i << 2), 3'h0);
			rd_count();
			c0 = got;
			repeat (1022) @(posedge clk_sys_in);
			rd_count();
			check_near(got, c0 + exp_ticks(i, 1024) - 16'h0001, 16'h0002);
		end
		// Compare first, mode last; the last two runs leave the toggle disabled.
		for (j = 0; j < 6; j++) begin
			rd_count();
			cmp = got + 16'h0008 + 16'($random(seed) & 31);
			// Odd runs load the compare by bytes, low byte first, so no early match can form.
			if (j[0]) begin
				bus(1, MATCH_VALUE_ADDR, ACC_BYTE, 0, {8'h00, cmp[7:0]}, 3'h0);
				bus(1, MATCH_VALUE_ADDR + 16'h0001, ACC_BYTE, 0, {8'h00, cmp[15:8]}, 3'h0);
			end else begin
				bus(1, MATCH_VALUE_ADDR, ACC_WORD, 1, cmp, 3'h0);
			end
			bus(1, MATCH_VALUE_ADDR, ACC_WORD, 0, 16'($random(seed)), 3'h0);
			bus(1, TIMER_MODE_CTRL_ADDR, ACC_BYTE, 0, (j < 4) ? 16'h0001 : 16'h0000, 3'h0);
			for (k = 0; k < 300 && irq !== 1'b1; k++) begin
				@(posedge clk_sys_in);
				#1;
			end
			if (k == 300) begin
				mismatches++;
				$display("BAD %0t no match request", $time);
				conclude();
			end
			t_exp = t_exp ^ (j < 4);
			check_eq(16'(tog), 16'(t_exp));
			check_eq(16'(irq), 16'h0001);
			repeat (3) begin
				@(posedge clk_sys_in);
				#1;
				check_eq(16'(irq), 16'h0000);
			end
			rd_count();
			check_near(got, cmp, 16'h0003);
		end
		check_eq(16'(edges), 16'h0004);
		// Edge codes run from both edges down to none, so none compares to a real value.
		for (i = 3; i >= 0; i--) begin
			bus(1, TIMER_MODE_CTRL_ADDR, ACC_BYTE, 0, 16'(i << 4), 3'h0);
			for (k = 0; k < 2; k++) begin
				rd_count();
				c0 = got;
				bus(0, CAPTURE_VALUE_ADDR, ACC_WORD, 1, 16'h0000, 3'h0);
				c1 = got;
				ext_in = ~ext_in;
				repeat (20) @(posedge clk_sys_in);
				bus(0, CAPTURE_VALUE_ADDR, ACC_WORD, 1, 16'h0000, 3'h0);
				if (i[k])
					check_near(got, c0, 16'h0004);
				else
					check_eq(got, c1);
			end
		end
		conclude();
	end
endmodule : free_running_timer_toggle_output_bench
